// *** hw/dsp_regfmt_consts.svh ***
// Constants for the DSP register transfer and format block
`ifndef DSP_REGFMT_CONSTS_SVH
`define DSP_REGFMT_CONSTS_SVH
`define DATA_W        32
`define ACC_W         40
`define GUARD_W       8
`define GUARD_LSB     32
`define HALF_LSB      16
`define REG_RST       32'h0000_0000
`define ACC_RST       40'h00_0000_0000
`define GUARD_RST     8'h00
`endif

// *** hw/dsp_regfmt_pkg.sv ***
// Types for the DSP register transfer and format block
package dsp_regfmt_pkg;
  // Register selector
  typedef enum logic [3:0] {
    SEL_ACCUM_0          = 4'h0,
    SEL_ACCUM_1          = 4'h1,
    SEL_GUARD_EXT_0      = 4'h2,
    SEL_GUARD_EXT_1      = 4'h3,
    SEL_X_OPERAND_FIRST  = 4'h4,
    SEL_X_OPERAND_SECOND = 4'h5,
    SEL_Y_OPERAND_FIRST  = 4'h6,
    SEL_Y_OPERAND_SECOND = 4'h7,
    SEL_MULT_INPUT_FIRST = 4'h8,
    SEL_MULT_INPUT_SECOND = 4'h9
  } reg_sel_t;

  // Transfer opcodes
  typedef enum logic [1:0] {
    XFER_NONE            = 2'h0,
    SINGLE_TRANSFER_WORD = 2'h1,
    SINGLE_TRANSFER_LONG = 2'h2,
    XY_BUS_WORD_MOVE     = 2'h3
  } xfer_op_t;

  // Operation classes of the arithmetic unit
  typedef enum logic [2:0] {
    OP_FIXED          = 3'h0,
    MSB_DETECT_OP     = 3'h1,
    ARITH_SHIFT_OP    = 3'h2,
    OP_INTEGER        = 3'h3,
    OP_LOGIC          = 3'h4,
    LOGIC_SHIFT_OP    = 3'h5,
    SIGNED_MULTIPLY_OP = 3'h6
  } op_class_t;

  // Transfer request from the memory side
  typedef struct packed {
    logic        valid;
    xfer_op_t    op;
    logic        load;
    reg_sel_t    sel;
    logic [31:0] data;
  } xfer_req_t;

  // Operand read request from the arithmetic unit
  typedef struct packed {
    op_class_t cls;
    reg_sel_t  sel;
  } src_req_t;

  // Result write request from the arithmetic unit
  typedef struct packed {
    logic      valid;
    op_class_t cls;
    reg_sel_t  sel;
    logic [39:0] result;
  } dst_req_t;

  // Register set state
  typedef struct packed {
    logic [39:0] acc_0;
    logic [39:0] acc_1;
    logic [31:0] x0;
    logic [31:0] x1;
    logic [31:0] y0;
    logic [31:0] y1;
    logic [31:0] m0;
    logic [31:0] m1;
    logic [31:0] store_data;
    logic        store_valid;
    logic        illegal;
  } regset_t;
endpackage

// *** hw/dsp_src_format.sv ***
// Source operand widening for the arithmetic unit
`timescale 1ns/1ps
`include "dsp_regfmt_consts.svh"
module dsp_src_format (
  // Request
  input  dsp_regfmt_pkg::op_class_t cls_i,
  input  wire logic                 is_acc_i,
  input  wire logic [39:0]          raw_i,
  // Operand
  output logic [39:0]               operand_o
);
  import dsp_regfmt_pkg::*;

  always_comb begin
    operand_o = raw_i;
    case (cls_i)
      OP_FIXED, MSB_DETECT_OP, ARITH_SHIFT_OP: begin
        if (!is_acc_i) begin
          operand_o = {{`GUARD_W{raw_i[31]}}, raw_i[31:0]};
        end
      end
      OP_INTEGER: begin
        if (is_acc_i) begin
          operand_o = {raw_i[39:16], 16'h0000};
        end else begin
          operand_o = {{`GUARD_W{raw_i[31]}}, raw_i[31:16], 16'h0000};
        end
      end
      default: begin
        operand_o = {8'h00, raw_i[31:16], 16'h0000};
      end
    endcase
  end
endmodule

// *** hw/dsp_register_transfer_format.sv ***
// DSP register set with transfer and result formatting
`timescale 1ns/1ps
`include "dsp_regfmt_consts.svh"
// Function
// - Every DSP register reachable from data bus
// - Single transfers support word and longword
// - Word transfer uses upper half bits
// - Longword transfer uses all 32 bits
// - Guard extensions are bits 39:32 of the accumulators
// - Guard store sign-extends its 8 bits
// - Guard load keeps accumulator low bits
// - Signed multiply rejects accum_0 as source
// - Non-accumulator fixed sources sign-extend to 40
// - Integer ops ignore and clear low half
// - Non-accumulator destinations drop guard bits
// - X/Y word moves use upper half
module dsp_register_transfer_format (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Instruction data bus and X/Y buses
  input  dsp_regfmt_pkg::xfer_req_t xfer_i,
  output logic [31:0]               store_data_o,
  output logic                      store_valid_o,
  // Arithmetic unit source
  input  dsp_regfmt_pkg::src_req_t  src_i,
  output logic [39:0]               src_operand_o,
  output logic                      src_illegal_o,
  // Arithmetic unit destination
  input  dsp_regfmt_pkg::dst_req_t  dst_i,
  output logic                      dst_illegal_o
);
  import dsp_regfmt_pkg::*;

  regset_t     state_ff;
  regset_t     nxt_state;
  logic [39:0] src_raw;
  logic        src_is_acc;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_acc(input reg_sel_t s);
    is_acc = (s == SEL_ACCUM_0) || (s == SEL_ACCUM_1);
  endfunction

  function automatic logic is_guard(input reg_sel_t s);
    is_guard = (s == SEL_GUARD_EXT_0) || (s == SEL_GUARD_EXT_1);
  endfunction

  function automatic logic sel_ok(input reg_sel_t s);
    sel_ok = (s <= SEL_MULT_INPUT_SECOND);
  endfunction

  // Raw 40-bit view of any register
  function automatic logic [39:0] read_reg(input regset_t st, input reg_sel_t s);
    read_reg = `ACC_RST;
    case (s)
      SEL_ACCUM_0, SEL_GUARD_EXT_0: read_reg = st.acc_0;
      SEL_ACCUM_1, SEL_GUARD_EXT_1: read_reg = st.acc_1;
      SEL_X_OPERAND_FIRST:  read_reg = {8'h00, st.x0};
      SEL_X_OPERAND_SECOND: read_reg = {8'h00, st.x1};
      SEL_Y_OPERAND_FIRST:  read_reg = {8'h00, st.y0};
      SEL_Y_OPERAND_SECOND: read_reg = {8'h00, st.y1};
      SEL_MULT_INPUT_FIRST: read_reg = {8'h00, st.m0};
      SEL_MULT_INPUT_SECOND: read_reg = {8'h00, st.m1};
      default: read_reg = `ACC_RST;
    endcase
  endfunction

  // Write a 32-bit value to a non-accumulator register
  function automatic regset_t write_gp(input regset_t st, input reg_sel_t s,
                                       input logic [31:0] v);
    write_gp = st;
    case (s)
      SEL_X_OPERAND_FIRST:  write_gp.x0 = v;
      SEL_X_OPERAND_SECOND: write_gp.x1 = v;
      SEL_Y_OPERAND_FIRST:  write_gp.y0 = v;
      SEL_Y_OPERAND_SECOND: write_gp.y1 = v;
      SEL_MULT_INPUT_FIRST: write_gp.m0 = v;
      SEL_MULT_INPUT_SECOND: write_gp.m1 = v;
      default: write_gp = st;
    endcase
  endfunction

  // Write a 40-bit value to an accumulator
  function automatic regset_t write_acc(input regset_t st, input reg_sel_t s,
                                        input logic [39:0] v);
    write_acc = st;
    if (s == SEL_ACCUM_0 || s == SEL_GUARD_EXT_0) begin
      write_acc.acc_0 = v;
    end else begin
      write_acc.acc_1 = v;
    end
  endfunction

  // ----------------------------------------
  // Source operand path
  // ----------------------------------------
  assign src_raw    = read_reg(state_ff, src_i.sel);
  assign src_is_acc = is_acc(src_i.sel);

  always_comb begin
    src_illegal_o = !sel_ok(src_i.sel) || is_guard(src_i.sel);
    if (src_i.cls == SIGNED_MULTIPLY_OP && src_i.sel == SEL_ACCUM_0) begin
      src_illegal_o = 1'b1;
    end
  end

  dsp_src_format u_src_format (
    .cls_i     (src_i.cls),
    .is_acc_i  (src_is_acc),
    .raw_i     (src_raw),
    .operand_o (src_operand_o)
  );

  always_comb begin
    dst_illegal_o = dst_i.valid && (!sel_ok(dst_i.sel) || is_guard(dst_i.sel));
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [39:0] cur;
    logic [39:0] res;
    logic [31:0] d;
    cur = `ACC_RST;
    res = `ACC_RST;
    d   = `REG_RST;
    nxt_state = state_ff;
    nxt_state.store_valid = 1'b0;
    nxt_state.illegal     = 1'b0;

    // Result write from the arithmetic unit
    if (dst_i.valid && sel_ok(dst_i.sel) && !is_guard(dst_i.sel)) begin
      res = dst_i.result;
      if (is_acc(dst_i.sel)) begin
        case (dst_i.cls)
          OP_FIXED, ARITH_SHIFT_OP, SIGNED_MULTIPLY_OP: begin
            nxt_state = write_acc(nxt_state, dst_i.sel, res);
          end
          OP_INTEGER, MSB_DETECT_OP: begin
            nxt_state = write_acc(nxt_state, dst_i.sel,
                                  {res[39:16], 16'h0000});
          end
          default: begin
            nxt_state = write_acc(nxt_state, dst_i.sel,
                                  {8'h00, res[31:16], 16'h0000});
          end
        endcase
      end else begin
        case (dst_i.cls)
          OP_FIXED, ARITH_SHIFT_OP, SIGNED_MULTIPLY_OP: begin
            nxt_state = write_gp(nxt_state, dst_i.sel, res[31:0]);
          end
          default: begin
            nxt_state = write_gp(nxt_state, dst_i.sel, {res[31:16], 16'h0000});
          end
        endcase
      end
    end

    // Memory transfer, later in order so a load wins over a result write
    if (xfer_i.valid && xfer_i.op != XFER_NONE) begin
      if (!sel_ok(xfer_i.sel) ||
          (xfer_i.op == XY_BUS_WORD_MOVE && is_guard(xfer_i.sel))) begin
        nxt_state.illegal = 1'b1;
      end else if (xfer_i.load) begin
        d   = xfer_i.data;
        cur = read_reg(nxt_state, xfer_i.sel);
        if (is_guard(xfer_i.sel)) begin
          nxt_state = write_acc(nxt_state, xfer_i.sel, {d[7:0], cur[31:0]});
        end else if (xfer_i.op == SINGLE_TRANSFER_LONG) begin
          if (is_acc(xfer_i.sel)) begin
            nxt_state = write_acc(nxt_state, xfer_i.sel,
                                  {{`GUARD_W{d[31]}}, d});
          end else begin
            nxt_state = write_gp(nxt_state, xfer_i.sel, d);
          end
        end else begin
          // Word data arrives in the low half of the bus
          if (is_acc(xfer_i.sel)) begin
            nxt_state = write_acc(nxt_state, xfer_i.sel,
                                  {{`GUARD_W{d[15]}}, d[15:0], 16'h0000});
          end else begin
            nxt_state = write_gp(nxt_state, xfer_i.sel,
                                 {d[15:0], 16'h0000});
          end
        end
      end else begin
        cur = read_reg(state_ff, xfer_i.sel);
        nxt_state.store_valid = 1'b1;
        if (is_guard(xfer_i.sel)) begin
          nxt_state.store_data = {{24{cur[39]}}, cur[39:32]};
        end else if (xfer_i.op == SINGLE_TRANSFER_LONG) begin
          nxt_state.store_data = cur[31:0];
        end else begin
          nxt_state.store_data = {{16{cur[31]}}, cur[31:16]};
        end
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign store_data_o  = state_ff.store_data;
  assign store_valid_o = state_ff.store_valid;
endmodule

// *** tb/dsp_regfmt_checker.sv ***
// Assertion checker for the DSP register block
`timescale 1ns/1ps
module dsp_regfmt_checker
  import dsp_regfmt_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  // Block ports
  input wire xfer_req_t   xfer_i,
  input wire logic [31:0] store_data_o,
  input wire logic        store_valid_o,
  input wire src_req_t    src_i,
  input wire logic [39:0] src_operand_o,
  input wire logic        src_illegal_o,
  input wire dst_req_t    dst_i,
  input wire logic        dst_illegal_o
);
  logic [31:0] d, w16;
  logic [15:0] hi;
  logic        st, gp, gpd, sgn;
  assign d   = xfer_i.data;
  assign sgn = d[31];
  assign w16 = {{16{d[15]}}, d[15:0]};
  assign hi  = dst_i.result[31:16];
  assign st  = xfer_i.valid && !xfer_i.load && xfer_i.op inside {2'h1, 2'h2};
  assign gp  = xfer_i.sel inside {[4'h4:4'h9]};
  assign gpd = dst_i.sel inside {[4'h4:4'h9]};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ld(o);
    xfer_i.valid && xfer_i.load && xfer_i.op == o && (xfer_i.sel < 2 || gp);
  endsequence
  sequence s_st(o);
    st && xfer_i.op == o && xfer_i.sel == $past(xfer_i.sel);
  endsequence
  property p_store;
    st && xfer_i.sel <= 4'h9 |=> store_valid_o;
  endproperty
  a_store: assert property (p_store) else $error("store pulse missing");
  property p_refuse;
    xfer_i.valid && (xfer_i.load || xfer_i.sel > 4'h9) |=> !store_valid_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unexpected store pulse");
  property p_long;
    s_ld(SINGLE_TRANSFER_LONG) ##1 s_st(SINGLE_TRANSFER_LONG) |=> store_data_o == $past(d, 2);
  endproperty
  a_long: assert property (p_long) else $error("long round trip wrong");
  property p_word;
    s_ld(SINGLE_TRANSFER_WORD) ##1 s_st(SINGLE_TRANSFER_WORD) |=> store_data_o == $past(w16, 2);
  endproperty
  a_word: assert property (p_word) else $error("word round trip wrong");
  property p_gsext;
    (s_ld(SINGLE_TRANSFER_LONG) ##0 xfer_i.sel == SEL_ACCUM_0) ##1
    (st && xfer_i.sel == SEL_GUARD_EXT_0) |=> store_data_o == {32{$past(sgn, 2)}};
  endproperty
  a_gsext: assert property (p_gsext) else $error("guard store wrong");
  property p_gkeep;
    (s_ld(SINGLE_TRANSFER_LONG) ##0 xfer_i.sel == SEL_ACCUM_0) ##1
    (xfer_i.load && xfer_i.sel == SEL_GUARD_EXT_0 && !dst_i.valid) ##1
    (st && xfer_i.op == SINGLE_TRANSFER_LONG && xfer_i.sel == SEL_ACCUM_0)
    |=> store_data_o == $past(d, 3);
  endproperty
  a_gkeep: assert property (p_gkeep) else $error("guard load touched low");
  property p_mul;
    src_i.cls == SIGNED_MULTIPLY_OP && src_i.sel < 2 |-> src_illegal_o == (src_i.sel == 0);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply source check wrong");
  property p_fix;
    (s_ld(SINGLE_TRANSFER_LONG) ##0 gp) ##1
    (src_i.cls == OP_FIXED && src_i.sel == $past(xfer_i.sel))
    |-> src_operand_o == {{8{$past(sgn)}}, $past(d)};
  endproperty
  a_fix: assert property (p_fix) else $error("fixed source not widened");
  property p_int;
    (dst_i.valid && dst_i.cls == OP_INTEGER && gpd && !xfer_i.valid) ##1
    (st && xfer_i.op == SINGLE_TRANSFER_LONG && xfer_i.sel == $past(dst_i.sel))
    |=> store_data_o == {$past(hi, 2), 16'h0000};
  endproperty
  a_int: assert property (p_int) else $error("integer result wrong");
endmodule

bind dsp_register_transfer_format dsp_regfmt_checker dsp_regfmt_checker_inst (
  .sys_clk_i, .rst_i, .xfer_i, .store_data_o, .store_valid_o, .src_i,
  .src_operand_o, .src_illegal_o, .dst_i, .dst_illegal_o);

// *** tb/dsp_mem_side_model.sv ***
// Memory side model that takes in store beats
`timescale 1ns/1ps
module dsp_mem_side_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        store_valid_i,
  input  wire logic [31:0] store_data_i,
  output logic [31:0]      mem_word_o,
  output int               stores_o
);
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stores_o   <= 0;
      mem_word_o <= 32'h0000_0000;
    end else if (store_valid_i) begin
      stores_o   <= stores_o + 1;
      mem_word_o <= store_data_i;
    end
  end
endmodule

// *** tb/dsp_register_transfer_format_bench.sv ***
// Random and directed bench for the DSP register block
`timescale 1ns/1ps
module dsp_register_transfer_format_bench;
  import dsp_regfmt_pkg::*;
  logic sys_clk_i, rst_i, store_valid_o, src_illegal_o, dst_illegal_o;
  logic [31:0] store_data_o, mem_word, exp_sd;
  logic [39:0] src_operand_o;
  logic [39:0] r [10];
  xfer_req_t xfer_i;
  src_req_t  src_i;
  dst_req_t  dst_i;
  int        errors, tests_run, stores, exp_st;
  dsp_register_transfer_format dsp_register_transfer_format_inst (.sys_clk_i, .rst_i,
    .xfer_i, .store_data_o, .store_valid_o, .src_i, .src_operand_o, .src_illegal_o,
    .dst_i, .dst_illegal_o);
  dsp_mem_side_model dsp_mem_side_model_inst (.sys_clk_i, .rst_i,
    .store_valid_i(store_valid_o), .store_data_i(store_data_o), .mem_word_o(mem_word),
    .stores_o(stores));
  initial begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ----
  // Expectation helpers
  // ----
  function automatic xfer_req_t xr(int o, int l, int s, logic [31:0] v);
    return {1'b1, 2'(o), 1'(l), 4'(s), v};
  endfunction
  function automatic dst_req_t dr(int c, int s, logic [39:0] v);
    return {1'b1, 3'(c), 4'(s), v};
  endfunction
  function automatic logic [39:0] src_val(src_req_t s);
    logic [39:0] v;
    v = s.sel < 2 ? r[s.sel] : {{8{r[s.sel][31]}}, r[s.sel][31:0]};
    if (s.cls == OP_INTEGER) v[15:0] = 16'h0000;
    else if (s.cls > ARITH_SHIFT_OP) v = {8'h00, v[31:16], 16'h0000};
    return v;
  endfunction
  task automatic chk(string n, logic [39:0] e, logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", n, e, g);
    end
  endtask
  task automatic step(xfer_req_t x, dst_req_t d = '0, src_req_t s = '0);
    logic [39:0] v;
    logic ok, si, wr;
    int n;
    xfer_i = x; dst_i = d; src_i = s;
    #1;
    si = s.sel > 9 || s.sel inside {2, 3} || (s.cls == SIGNED_MULTIPLY_OP && s.sel == 0);
    chk("src_illegal", 40'(si), 40'(src_illegal_o));
    if (!si) chk("src_operand", src_val(s), src_operand_o);
    ok = d.valid && d.sel <= 9 && !(d.sel inside {2, 3});
    chk("dst_illegal", 40'(d.valid && !ok), 40'(dst_illegal_o));
    v = d.result;
    if (d.cls inside {MSB_DETECT_OP, OP_INTEGER}) v[15:0] = 16'h0000;
    if (d.cls inside {OP_LOGIC, LOGIC_SHIFT_OP}) v = {8'h00, v[31:16], 16'h0000};
    if (d.sel > 1) v[39:32] = 8'h00;
    wr = ok;
    n = x.sel;
    ok = x.valid && x.op != XFER_NONE && n <= 9 && !(x.op == XY_BUS_WORD_MOVE && n inside {2, 3});
    // Store reads registers as they stood before this edge's writes
    if (ok && !x.load) begin
      exp_st++;
      if (n inside {2, 3}) exp_sd = {{24{r[n-2][39]}}, r[n-2][39:32]};
      else exp_sd = x.op == SINGLE_TRANSFER_LONG ? r[n][31:0] : {{16{r[n][31]}}, r[n][31:16]};
    end
    if (wr) r[d.sel] = v;
    if (ok && x.load) begin
      if (n inside {2, 3}) r[n-2][39:32] = x.data[7:0];
      else if (x.op == SINGLE_TRANSFER_LONG) r[n] = {{8{n < 2 && x.data[31]}}, x.data};
      else r[n] = {{8{n < 2 && x.data[15]}}, x.data[15:0], 16'h0000};
    end
    @(negedge sys_clk_i);
    chk("store_valid", 40'(ok && !x.load), 40'(store_valid_o));
    chk("store_data", 40'(exp_sd), 40'(store_data_o));
  endtask
  task automatic wrap_up;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    wrap_up();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(62));
    rst_i = 1; xfer_i = '0; dst_i = '0; src_i = '0;
    errors = 0; tests_run = 0; exp_st = 0; exp_sd = 32'h0000_0000;
    foreach (r[i]) r[i] = 40'h00_0000_0000;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i) rst_i = 0;
    step(xr(2, 1, 0, 32'h8000_0000));
    step(xr(2, 0, 2, 0));
    step(xr(2, 1, 0, 32'h1234_5678));
    step(xr(1, 1, 2, 32'h0000_005A));
    step(xr(2, 0, 0, 0));
    step(xr(1, 0, 2, 0));
    step(xr(2, 1, 4, 32'hCAFE_F00D));
    step(xr(2, 0, 4, 0), '0, {OP_FIXED, SEL_X_OPERAND_FIRST});
    step(xr(1, 1, 5, 32'hABCD_8123));
    step(xr(1, 0, 5, 0));
    step(xr(3, 1, 6, 32'h0000_9ABC));
    step(xr(3, 0, 2, 0));
    step(xr(2, 0, 10, 0));
    step('0, dr(3, 7, 40'hFF_1234_5678));
    step(xr(2, 0, 7, 0));
    step('0, dr(4, 0, 40'hFF_8765_4321));
    step(xr(2, 0, 2, 0), '0, {SIGNED_MULTIPLY_OP, SEL_ACCUM_0});
    step('0, '0, {SIGNED_MULTIPLY_OP, SEL_ACCUM_1});
    repeat (400) step(xr($urandom % 4, $urandom % 2, $urandom % 12, $urandom),
      {1'($urandom % 4 == 0), 3'($urandom % 7), 4'($urandom % 12), 40'({$urandom, $urandom})},
      {3'($urandom % 7), 4'($urandom % 12)});
    step('0);
    chk("store_count", 40'(exp_st), 40'(stores));
    chk("mem_word", 40'(exp_sd), 40'(mem_word));
    wrap_up();
  end
endmodule
